// ===== logic/sbsr_consts.svh
// Register offsets, field positions, reset values and codes for the status byte block
`ifndef SBSR_CONSTS_SVH
`define SBSR_CONSTS_SVH

// Register byte offsets
`define SBSR_OFF_STB     12'h000
`define SBSR_OFF_POLL    12'h004
`define SBSR_OFF_SRE     12'h008
`define SBSR_OFF_OPEV    12'h00C
`define SBSR_OFF_OPEN    12'h010
`define SBSR_OFF_QEV     12'h014
`define SBSR_OFF_QEN     12'h018
`define SBSR_OFF_ESR     12'h01C
`define SBSR_OFF_ESE     12'h020
`define SBSR_OFF_OQ      12'h024
`define SBSR_OFF_CMD     12'h028
`define SBSR_OFF_STAT    12'h02C

// Status byte bit positions
`define SBSR_BIT_QUES    3
`define SBSR_BIT_MAV     4
`define SBSR_BIT_ESB     5
`define SBSR_BIT_MSS     6
`define SBSR_BIT_OPER    7

// Standard event bits and reset values
`define SBSR_ESR_OPC     0
`define SBSR_ESR_RST     8'h80
`define SBSR_SRE_MASK    8'hBF

// Output queue
`define SBSR_OQ_DEPTH    5'h10
`define SBSR_OPC_REPLY   8'h01

// Command kinds in CMD[2:0]
`define SBSR_CMD_SEQ     3'h0
`define SBSR_CMD_PAR     3'h1
`define SBSR_CMD_WAI     3'h2
`define SBSR_CMD_OPCQ    3'h3
`define SBSR_CMD_OPCS    3'h4

`endif

// ===== logic/sbsr_pkg.sv
// Types for the status byte block
package sbsr_pkg;
   // Command sequencer states
   typedef enum logic [2:0] {
      SQ_IDLE = 3'b001,
      SQ_SEQ  = 3'b010,
      SQ_WAI  = 3'b100
   } sbsr_seq_t;

   // Transient trigger state codes
   typedef enum logic [2:0] {
      TRG_IDLE = 3'b001,
      TRG_ARM  = 3'b010,
      TRG_BUSY = 3'b100
   } sbsr_trig_t;
endpackage

// ===== logic/sbsr_top.sv
// Status byte, service request, output queue and command completion over APB
// Operation
// RULE_01: Status byte read returns contents, clears nothing, summary in bit 6.
// RULE_02: Serial poll returns latched request bit in bit 6 and clears it.
// RULE_03: Master summary is unlatched OR of enabled status byte bits.
// RULE_04: Requesting service raises SRQ and latches request bit into bit 6.
// RULE_05: Poll clear of request bit leaves all other status bits alone.
// RULE_06: Output queue is a FIFO holding messages until controller reads them.
// RULE_07: Bit 4 is set whenever the output queue holds a byte.
// RULE_08: Reading an event register clears it and its summary bit.
// RULE_09: Controller writes 8 to service enable for questionable requests.
// RULE_10: Questionable mask 11 passes bits 0, 1 and 3 into its summary.
// RULE_11: Sequential commands finish before the next; parallel ones overlap.
// RULE_12: Wait command stalls later commands until non-transient ops finish.
// RULE_13: Operation-complete query queues value 1 once nothing is pending.
// RULE_14: Operation-complete command sets the complete bit; commands go on.
// RULE_15: Trigger state reads as idle, armed or busy.
// RULE_16: Event registers latch asserted conditions until read, then clear.
// RULE_17: Enabled operation events OR into status byte bit 7.
// RULE_18: Enabled standard events OR into status byte bit 5.
// RULE_19: SRQ is released once a poll clears the request bit.
`include "sbsr_consts.svh"

module sbsr_top (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic [15:0] OPER_COND,
   input  wire logic [15:0] QUES_COND,
   input  wire logic [7:0]  ESR_EVENTS,
   input  wire logic        MSG_VALID,
   input  wire logic [7:0]  MSG_DATA,
   output logic             MSG_READY,
   input  wire logic        SEQ_DONE,
   input  wire logic        PAR_BUSY,
   input  wire logic        TRANS_BUSY,
   input  wire logic        TRIG_ARMED,
   input  wire logic        TRIG_BUSY,
   output logic             CMD_START,
   output logic             CMD_PARALLEL,
   output logic      [7:0]  CMD_CODE,
   output logic             SRQ
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [15:0]          oper_evt_ff, nxt_oper_evt;
   logic [15:0]          oper_en_ff,  nxt_oper_en;
   logic [15:0]          ques_evt_ff, nxt_ques_evt;
   logic [15:0]          ques_en_ff,  nxt_ques_en;
   logic [7:0]           esr_ff,      nxt_esr;
   logic [7:0]           ese_ff,      nxt_ese;
   logic [7:0]           sre_ff,      nxt_sre;
   logic                 rqs_ff,      nxt_rqs;
   logic                 mss_d_ff,    nxt_mss_d;
   logic [31:0]          prdata_ff,   nxt_prdata;
   logic [7:0]           oq_mem [0:15];
   logic [3:0]           wr_ptr_ff,   nxt_wr_ptr;
   logic [3:0]           rd_ptr_ff,   nxt_rd_ptr;
   logic [4:0]           cnt_ff,      nxt_cnt;
   sbsr_pkg::sbsr_seq_t  seq_ff,      nxt_seq;
   sbsr_pkg::sbsr_trig_t trig_ff,     nxt_trig;
   logic                 opcq_ff,     nxt_opcq;
   logic                 opcs_ff,     nxt_opcs;
   logic                 start_ff,    nxt_start;
   logic                 par_ff,      nxt_par;
   logic [7:0]           code_ff,     nxt_code;
   logic                 rd_setup, acc, wr_acc, cmd_wr, mapped, ro_reg;
   logic                 oper_sum, ques_sum, esb, mav, mss, pending;
   logic [7:0]           stb_base;
   logic                 push, pop, opc_push, opc_set;
   logic [7:0]           push_data;
   logic [31:0]          rd_val;

   ////////////////////////////////////////////////////////////////////////////
   // Bus phase decode
   assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
   assign acc      = PSEL & PENABLE;
   assign wr_acc   = acc & PWRITE & PREADY;
   assign cmd_wr   = wr_acc & (PADDR == `SBSR_OFF_CMD);

   // Address map check
   always_comb begin
      case (PADDR)
         `SBSR_OFF_STB, `SBSR_OFF_POLL, `SBSR_OFF_OPEV, `SBSR_OFF_QEV,
         `SBSR_OFF_ESR, `SBSR_OFF_OQ, `SBSR_OFF_STAT: begin
            mapped = 1'b1;
            ro_reg = 1'b1;
         end
         `SBSR_OFF_SRE, `SBSR_OFF_OPEN, `SBSR_OFF_QEN, `SBSR_OFF_ESE,
         `SBSR_OFF_CMD: begin
            mapped = 1'b1;
            ro_reg = 1'b0;
         end
         default: begin
            mapped = 1'b0;
            ro_reg = 1'b0;
         end
      endcase
   end

   // Command writes stall while a sequential or wait command is open
   assign PREADY  = ~(acc & PWRITE & (PADDR == `SBSR_OFF_CMD)
                    & (seq_ff != sbsr_pkg::SQ_IDLE)); // RULE_11 RULE_12
   assign PSLVERR = acc & PREADY & (~mapped | (PWRITE & ro_reg));
   assign PRDATA  = prdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Summary bits and status byte
   assign ques_sum = |(ques_evt_ff & ques_en_ff); // RULE_10
   assign oper_sum = |(oper_evt_ff & oper_en_ff); // RULE_17
   assign esb      = |(esr_ff & ese_ff); // RULE_18
   assign mav      = (cnt_ff != 5'h00); // RULE_07

   // Bit 6 left clear here; filled by the read that needs it
   always_comb begin
      stb_base                 = 8'h00;
      stb_base[`SBSR_BIT_QUES] = ques_sum;
      stb_base[`SBSR_BIT_MAV]  = mav;
      stb_base[`SBSR_BIT_ESB]  = esb;
      stb_base[`SBSR_BIT_OPER] = oper_sum;
   end

   // Live summary of enabled reasons for service
   assign mss = |(stb_base & sre_ff); // RULE_03 RULE_09

   ////////////////////////////////////////////////////////////////////////////
   // Read data mux, captured at the setup edge with its side effects
   always_comb begin
      rd_val = 32'h0000_0000;
      case (PADDR)
         `SBSR_OFF_STB: begin
            rd_val[7:0]          = stb_base; // RULE_01
            rd_val[`SBSR_BIT_MSS] = mss; // RULE_01
         end
         `SBSR_OFF_POLL: begin
            rd_val[7:0]          = stb_base; // RULE_02
            rd_val[`SBSR_BIT_MSS] = rqs_ff; // RULE_02
         end
         `SBSR_OFF_SRE:  rd_val[7:0]  = sre_ff;
         `SBSR_OFF_OPEV: rd_val[15:0] = oper_evt_ff;
         `SBSR_OFF_OPEN: rd_val[15:0] = oper_en_ff;
         `SBSR_OFF_QEV:  rd_val[15:0] = ques_evt_ff;
         `SBSR_OFF_QEN:  rd_val[15:0] = ques_en_ff;
         `SBSR_OFF_ESR:  rd_val[7:0]  = esr_ff;
         `SBSR_OFF_ESE:  rd_val[7:0]  = ese_ff;
         `SBSR_OFF_OQ: begin
            rd_val[7:0] = oq_mem[rd_ptr_ff];
            rd_val[8]   = mav;
         end
         `SBSR_OFF_STAT: begin
            rd_val[2:0]  = trig_ff; // RULE_15
            rd_val[5:3]  = seq_ff;
            rd_val[6]    = opcq_ff;
            rd_val[7]    = opcs_ff;
            rd_val[12:8] = cnt_ff;
         end
         default: rd_val = 32'h0000_0000;
      endcase
      if (!mapped) begin
         rd_val = 32'h0000_0000;
      end
   end

   // Read data register
   always_comb begin
      nxt_prdata = rd_setup ? rd_val : prdata_ff;
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         prdata_ff <= 32'h0000_0000;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event and enable registers; a new condition beats a read clear
   always_comb begin
      nxt_oper_evt = ((rd_setup & (PADDR == `SBSR_OFF_OPEV)) ? 16'h0000
                      : oper_evt_ff) | OPER_COND; // RULE_16 RULE_08
      nxt_ques_evt = ((rd_setup & (PADDR == `SBSR_OFF_QEV)) ? 16'h0000
                      : ques_evt_ff) | QUES_COND; // RULE_16 RULE_08
      nxt_esr      = ((rd_setup & (PADDR == `SBSR_OFF_ESR)) ? 8'h00
                      : esr_ff) | ESR_EVENTS; // RULE_16 RULE_08
      nxt_esr[`SBSR_ESR_OPC] = nxt_esr[`SBSR_ESR_OPC] | opc_set; // RULE_14
      nxt_oper_en  = oper_en_ff;
      nxt_ques_en  = ques_en_ff;
      nxt_ese      = ese_ff;
      nxt_sre      = sre_ff;
      if (wr_acc) begin
         case (PADDR)
            `SBSR_OFF_OPEN: nxt_oper_en = PWDATA[15:0];
            `SBSR_OFF_QEN:  nxt_ques_en = PWDATA[15:0]; // RULE_10
            `SBSR_OFF_ESE:  nxt_ese     = PWDATA[7:0];
            `SBSR_OFF_SRE:  nxt_sre     = PWDATA[7:0] & `SBSR_SRE_MASK; // RULE_09
            default:        nxt_sre     = sre_ff;
         endcase
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         oper_evt_ff <= 16'h0000;
         ques_evt_ff <= 16'h0000;
         esr_ff      <= `SBSR_ESR_RST;
         oper_en_ff  <= 16'h0000;
         ques_en_ff  <= 16'h0000;
         ese_ff      <= 8'h00;
         sre_ff      <= 8'h00;
      end else begin
         oper_evt_ff <= nxt_oper_evt;
         ques_evt_ff <= nxt_ques_evt;
         esr_ff      <= nxt_esr;
         oper_en_ff  <= nxt_oper_en;
         ques_en_ff  <= nxt_ques_en;
         ese_ff      <= nxt_ese;
         sre_ff      <= nxt_sre;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request service latch; a new request beats the poll clear
   always_comb begin
      nxt_mss_d = mss;
      nxt_rqs   = (mss & ~mss_d_ff)
                | (rqs_ff & ~(rd_setup & (PADDR == `SBSR_OFF_POLL))); // RULE_04 RULE_05
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rqs_ff   <= 1'b0;
         mss_d_ff <= 1'b0;
      end else begin
         rqs_ff   <= nxt_rqs;
         mss_d_ff <= nxt_mss_d;
      end
   end

   // Service request line follows the latch
   assign SRQ = rqs_ff; // RULE_04 RULE_19

   ////////////////////////////////////////////////////////////////////////////
   // Output queue: completion reply has priority over device messages
   assign pending   = PAR_BUSY | TRANS_BUSY | (seq_ff != sbsr_pkg::SQ_IDLE);
   assign opc_push  = opcq_ff & ~pending & (cnt_ff != `SBSR_OQ_DEPTH); // RULE_13
   assign MSG_READY = (cnt_ff != `SBSR_OQ_DEPTH) & ~opc_push;
   assign push      = opc_push | (MSG_VALID & MSG_READY); // RULE_06
   assign push_data = opc_push ? `SBSR_OPC_REPLY : MSG_DATA; // RULE_13
   assign pop       = rd_setup & (PADDR == `SBSR_OFF_OQ) & mav; // RULE_06

   // Pointer and fill count next values
   always_comb begin
      nxt_wr_ptr = push ? wr_ptr_ff + 4'h1 : wr_ptr_ff;
      nxt_rd_ptr = pop ? rd_ptr_ff + 4'h1 : rd_ptr_ff;
      nxt_cnt    = cnt_ff + {4'h0, push} - {4'h0, pop};
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wr_ptr_ff <= 4'h0;
         rd_ptr_ff <= 4'h0;
         cnt_ff    <= 5'h00;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         cnt_ff    <= nxt_cnt;
      end
   end

   // Queue storage, no reset needed behind the pointers
   always_ff @(posedge CLK) begin
      if (push) begin
         oq_mem[wr_ptr_ff] <= push_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command sequencer and completion flags
   always_comb begin
      nxt_seq   = seq_ff;
      nxt_opcq  = opcq_ff & ~opc_push;
      nxt_opcs  = opcs_ff & pending;
      nxt_start = 1'b0;
      nxt_par   = par_ff;
      nxt_code  = code_ff;
      opc_set   = opcs_ff & ~pending; // RULE_14
      case (seq_ff)
         sbsr_pkg::SQ_IDLE: begin
            if (cmd_wr) begin
               nxt_code = PWDATA[15:8];
               case (PWDATA[2:0])
                  `SBSR_CMD_SEQ: begin
                     nxt_start = 1'b1;
                     nxt_par   = 1'b0;
                     nxt_seq   = sbsr_pkg::SQ_SEQ; // RULE_11
                  end
                  `SBSR_CMD_PAR: begin
                     nxt_start = 1'b1;
                     nxt_par   = 1'b1; // RULE_11
                  end
                  `SBSR_CMD_WAI:  nxt_seq  = sbsr_pkg::SQ_WAI; // RULE_12
                  `SBSR_CMD_OPCQ: nxt_opcq = 1'b1; // RULE_13
                  `SBSR_CMD_OPCS: nxt_opcs = 1'b1; // RULE_14
                  default:        nxt_seq  = sbsr_pkg::SQ_IDLE;
               endcase
            end
         end
         sbsr_pkg::SQ_SEQ: begin
            if (SEQ_DONE) begin
               nxt_seq = sbsr_pkg::SQ_IDLE; // RULE_11
            end
         end
         sbsr_pkg::SQ_WAI: begin
            if (!PAR_BUSY) begin
               nxt_seq = sbsr_pkg::SQ_IDLE; // RULE_12
            end
         end
         default: nxt_seq = sbsr_pkg::SQ_IDLE;
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         seq_ff   <= sbsr_pkg::SQ_IDLE;
         opcq_ff  <= 1'b0;
         opcs_ff  <= 1'b0;
         start_ff <= 1'b0;
         par_ff   <= 1'b0;
         code_ff  <= 8'h00;
      end else begin
         seq_ff   <= nxt_seq;
         opcq_ff  <= nxt_opcq;
         opcs_ff  <= nxt_opcs;
         start_ff <= nxt_start;
         par_ff   <= nxt_par;
         code_ff  <= nxt_code;
      end
   end

   assign CMD_START    = start_ff;
   assign CMD_PARALLEL = par_ff;
   assign CMD_CODE     = code_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Trigger state capture, busy outranks armed
   always_comb begin
      if (TRIG_BUSY) begin
         nxt_trig = sbsr_pkg::TRG_BUSY; // RULE_15
      end else if (TRIG_ARMED) begin
         nxt_trig = sbsr_pkg::TRG_ARM;
      end else begin
         nxt_trig = sbsr_pkg::TRG_IDLE;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         trig_ff <= sbsr_pkg::TRG_IDLE;
      end else begin
         trig_ff <= nxt_trig;
      end
   end

endmodule // sbsr_top

// ===== tb/sbsr_checker.sv
// Port-level assertions for the status byte block
module sbsr_checker (
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        CMD_START,
   input wire logic        CMD_PARALLEL,
   input wire logic [7:0]  CMD_CODE,
   input wire logic        SRQ
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   ////////////////////////////////////////////////////////////
   // Bus phase decodes
   logic rd_set;
   logic stb_set;
   logic poll_set;
   logic cmd_acc;
   assign rd_set   = PSEL && !PENABLE && !PWRITE;
   assign stb_set  = rd_set && PADDR == 12'h000;
   assign poll_set = rd_set && PADDR == 12'h004;
   assign cmd_acc  = PSEL && PENABLE && PWRITE && PREADY && PADDR == 12'h028;
   ////////////////////////////////////////////////////////////
   a_poll_bit6: assert property (poll_set |=> PRDATA[6] == $past(SRQ))
      else $error("poll bit 6 wrong");
   a_stb_keeps_srq: assert property (stb_set && SRQ |=> SRQ)
      else $error("status read dropped request");
   a_stb_low_zero: assert property (stb_set |=> PRDATA[2:0] == 3'h0)
      else $error("status low bits set");
   a_srq_fall_poll: assert property ($fell(SRQ) |-> $past(poll_set))
      else $error("request dropped without poll");
   a_rdata_hold: assert property (!rd_set |=> $stable(PRDATA))
      else $error("read data moved");
   a_slverr_phase: assert property (PSLVERR |-> PSEL && PENABLE)
      else $error("error outside access");
   a_start_cause: assert property (
      CMD_START |-> $past(cmd_acc) && $past(PWDATA[2:1]) == 2'h0)
      else $error("start without command");
   a_start_pulse: assert property (CMD_START |=> !CMD_START)
      else $error("start longer than one cycle");
   a_cmd_fields: assert property (
      cmd_acc && PWDATA[2:1] == 2'h0 |=> CMD_START && CMD_CODE == $past(PWDATA[15:8])
      && CMD_PARALLEL == $past(PWDATA[0]))
      else $error("command fields wrong");
endmodule // sbsr_checker

bind sbsr_top sbsr_checker sbsr_checker_inst (
   .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .CMD_START(CMD_START), .CMD_PARALLEL(CMD_PARALLEL), .CMD_CODE(CMD_CODE), .SRQ(SRQ));

// ===== tb/sbsr_host.sv
// Bus controller model: APB master for polls, queries and mask writes
module sbsr_host (
   input  wire logic        clk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus at time zero
   initial begin
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= 12'h000;
      pwdata  <= 32'h00000000;
   end
   ////////////////////////////////////////////////////////////
   // One transfer: setup, then access held until ready is seen
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // sbsr_host

// ===== tb/sbsr_top_tb.sv
// Self-checking bench for the status byte and service request block
module sbsr_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, psel, penable, pwrite, pready, pslverr, srq, msg_ready;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] oper_cond = 16'h0000, ques_cond = 16'h0000;
   logic msg_valid = 1'b0, seq_done = 1'b0, par_busy = 1'b0, trans_busy = 1'b0;
   logic trig_armed = 1'b0, trig_busy = 1'b0, cmd_start, cmd_parallel;
   logic [7:0] msg_data = 8'h00, cmd_code;
   logic [7:0] esr_events = 8'h00;
   int fails = 0, checked = 0;
   // Clock
   always #5 clk = ~clk;
   sbsr_top sbsr_top_inst (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .OPER_COND(oper_cond), .QUES_COND(ques_cond), .ESR_EVENTS(esr_events),
      .MSG_VALID(msg_valid), .MSG_DATA(msg_data), .MSG_READY(msg_ready), .SEQ_DONE(seq_done),
      .PAR_BUSY(par_busy), .TRANS_BUSY(trans_busy), .TRIG_ARMED(trig_armed),
      .TRIG_BUSY(trig_busy), .CMD_START(cmd_start), .CMD_PARALLEL(cmd_parallel),
      .CMD_CODE(cmd_code), .SRQ(srq));
   sbsr_host sbsr_host_inst (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   ////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      sbsr_host_inst.xfer(1'b1, a, d, q, e);
      cmp("wr slverr", {31'h0, !(a inside {12'h008, 12'h010, 12'h018, 12'h020, 12'h028})},
          {31'h0, e});
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      logic e;
      sbsr_host_inst.xfer(1'b0, a, 32'h0, q, e);
      cmp(what, exp, q);
      cmp("slverr", {31'h0, a > 12'h02C}, {31'h0, e});
   endtask
   task automatic ev(input logic op, input logic [15:0] b);
      @(posedge clk);
      oper_cond <= op ? b : 16'h0000;
      ques_cond <= op ? 16'h0000 : b;
      @(posedge clk);
      oper_cond <= 16'h0000;
      ques_cond <= 16'h0000;
   endtask
   task automatic wait_srq;
      int n;
      n = 0;
      while (srq !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      cmp("srq", 32'h1, {31'h0, srq});
   endtask
   ////////////////////////////////////////////////////////////
   // Questionable path, masking, polls and event clears
   task automatic t_ques;
      logic [15:0] b;
      rd(12'h01C, 32'h80, "esr reset");
      rd(12'h01C, 32'h0, "esr cleared");
      @(posedge clk);
      esr_events <= 8'h20;
      @(posedge clk);
      esr_events <= 8'h00;
      rd(12'h01C, 32'h20, "esr latch");
      rd(12'h030, 32'h0, "unmapped");
      wr(12'h018, 32'd11);
      wr(12'h008, 32'd8);
      ev(1'b0, 16'h0004);
      repeat (5) @(posedge clk);
      cmp("srq masked", 32'h0, {31'h0, srq});
      wr(12'h014, 32'hFFFF);
      rd(12'h014, 32'h4, "ques ev");
      for (int i = 0; i < 3; i++) begin
         b = 16'h1 << (i == 2 ? 3 : i);
         ev(1'b0, b);
         wait_srq();
         rd(12'h000, 32'h48, "stb");
         rd(12'h004, 32'h48, "poll");
         cmp("srq off", 32'h0, {31'h0, srq});
         rd(12'h000, 32'h48, "stb kept");
         rd(12'h014, {16'h0, b}, "ques ev");
         rd(12'h000, 32'h0, "stb clr");
      end
   endtask
   // Operation summary and output queue order
   task automatic t_oper_queue;
      wr(12'h010, 32'h10);
      wr(12'h008, 32'h80);
      ev(1'b1, 16'h0010);
      wait_srq();
      rd(12'h004, 32'hC0, "oper poll");
      rd(12'h00C, 32'h10, "oper ev");
      cmp("msg ready", 32'h1, {31'h0, msg_ready});
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         msg_valid <= 1'b1;
         msg_data  <= 8'hA0 + i[7:0];
      end
      @(posedge clk);
      msg_valid <= 1'b0;
      rd(12'h000, 32'h10, "stb mav");
      for (int i = 0; i < 3; i++)
         rd(12'h024, 32'h1A0 + i, "queue");
      rd(12'h000, 32'h0, "stb empty");
   endtask
   // Completion query and completion bit with a parallel command meanwhile
   task automatic t_opc;
      par_busy <= 1'b1;
      wr(12'h028, 32'h3);
      repeat (4) @(posedge clk);
      rd(12'h000, 32'h0, "no reply yet");
      par_busy <= 1'b0;
      repeat (4) @(posedge clk);
      rd(12'h024, 32'h101, "opc reply");
      wr(12'h020, 32'h1);
      wr(12'h008, 32'h20);
      par_busy <= 1'b1;
      wr(12'h028, 32'h4);
      wr(12'h028, 32'h5A01);
      @(posedge clk);
      cmp("parallel", 32'h1, {31'h0, cmd_parallel});
      cmp("srq early", 32'h0, {31'h0, srq});
      par_busy <= 1'b0;
      wait_srq();
      rd(12'h000, 32'h60, "stb esb");
      rd(12'h01C, 32'h1, "opc bit");
      rd(12'h004, 32'h40, "poll rqs");
   endtask
   // Sequential and wait commands hold off the next command
   task automatic t_stall(input logic [2:0] kind);
      time t0;
      wr(12'h028, {21'h0, 8'h11, kind});
      t0 = $time;
      fork
         wr(12'h028, 32'h2201);
         begin
            repeat (8) @(posedge clk);
            seq_done <= (kind == 3'h0);
            par_busy <= 1'b0;
            @(posedge clk);
            seq_done <= 1'b0;
         end
      join
      cmp("stalled", 32'h1, {31'h0, ($time - t0) > 80});
      @(posedge clk);
      cmp("code", 32'h22, {24'h0, cmd_code});
   endtask
   // Trigger state codes
   task automatic t_trig;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         trig_armed <= (i == 1);
         trig_busy  <= (i == 2);
         repeat (3) @(posedge clk);
         rd(12'h02C, 32'h8 | (32'h1 << i), "trig");
      end
   endtask
   ////////////////////////////////////////////////////////////
   // Verdict
   task automatic results;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_ques();
      t_oper_queue();
      t_opc();
      t_stall(3'h0);
      par_busy   <= 1'b1;
      trans_busy <= 1'b1;
      t_stall(3'h2);
      trans_busy <= 1'b0;
      t_trig();
      results();
   end
   // Watchdog
   initial begin
      #50000;
      fails++;
      results();
   end
endmodule // sbsr_top_tb
